// file: rtl/tapx_regs.vh
// Constants for the extended TAP instruction decoder.
// Behaviour
// - HIGHZ tri-states all user pins and selects bypass until another instruction loads.
// - After configuration an enabled pull-up or bus-hold beats the HIGHZ float.
// - CLAMP selects bypass and holds pins at boundary-scan register contents.
// - Clamp values come from cell update stage; pull-up or bus-hold overrides after configuration.
// - Reconfigure instruction pulses internal configuration request; the physical pin is untouched.
// - I/O setting instruction routes the scan path through the I/O setting chain.
// - Secure-enter sets secure mode; only six instructions are then accepted.
// - Secure enter and exit are accepted only from the core path in user mode.
// - Secure-exit leaves secure mode and reopens every supported instruction.
// - Volatile key erase instruction erases the stored volatile key.
// - Key verify instruction reports whether the non-volatile key is erased.
// - Pulse test drives data, inverted data in idle, then data again, on falling TCK.
// - Pulse and train tests only in user mode and on the variant offering them.
// - Train test also toggles outputs every falling TCK while staying in idle.
// - Identification is the active instruction after reset and in Test-Logic-Reset.
// - With tamper protection set before configuration is done, secure mode is active straight after reset.
`ifndef TAPX_REGS_VH
`define TAPX_REGS_VH
`define TAPX_IR_W        10
`define TAPX_I_SAMPLE    10'h005
`define TAPX_I_EXTEST    10'h00f
`define TAPX_I_BYPASS    10'h3ff
`define TAPX_I_USERCODE  10'h007
`define TAPX_I_IDCODE    10'h006
`define TAPX_I_HIGHZ     10'h00b
`define TAPX_I_CLAMP     10'h00a
`define TAPX_I_RECONF    10'h001
`define TAPX_I_IOSET     10'h00d
`define TAPX_I_LOCK      10'h1f0
`define TAPX_I_UNLOCK    10'h331
`define TAPX_I_KEYCLR    10'h029
`define TAPX_I_KEYVFY    10'h013
`define TAPX_I_PULSE     10'h08f
`define TAPX_I_TRAIN     10'h04f
`define TAPX_I_EDERR     10'h017
`define TAPX_IR_CAPTURE  10'h001
`define TAPX_ID_VALUE    32'h0000_0001
`define TAPX_S_RESET     4'h0
`define TAPX_S_IDLE      4'h1
`define TAPX_S_SELDR     4'h2
`define TAPX_S_CAPDR     4'h3
`define TAPX_S_SHDR      4'h4
`define TAPX_S_EX1DR     4'h5
`define TAPX_S_PAUDR     4'h6
`define TAPX_S_EX2DR     4'h7
`define TAPX_S_UPDR      4'h8
`define TAPX_S_SELIR     4'h9
`define TAPX_S_CAPIR     4'ha
`define TAPX_S_SHIR      4'hb
`define TAPX_S_EX1IR     4'hc
`define TAPX_S_PAUIR     4'hd
`define TAPX_S_EX2IR     4'he
`define TAPX_S_UPIR      4'hf
`endif

// file: rtl/tapx_pin_sync.v
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module tapx_pin_sync #(
  parameter W = 4
) (
  input  wire         core_clk,
  input  wire         rst_b,
  input  wire [W-1:0] pinIn,
  output reg  [W-1:0] pinOut
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;
  integer i;
  // A change counts only once the second and third stages agree, rejecting metastable glitches.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
      stage3 <= {W{1'b0}};
      pinOut <= {W{1'b0}};
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < W; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          pinOut[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// file: rtl/tapx_decode.v
// Extended TAP: state machine, instruction register and instruction effects.
`timescale 1ns/1ps
`include "tapx_regs.vh"
module tapx_decode #(
  parameter IR_W       = `TAPX_IR_W,
  parameter ID_VALUE   = `TAPX_ID_VALUE,
  parameter HAS_PULSE  = 1
) (
  input  wire            core_clk,
  input  wire            rst_b,
  input  wire            tck,
  input  wire            tms,
  input  wire            tdi,
  output reg             tdo,
  output reg             tdoEn,
  input  wire            coreAccess,
  input  wire            userMode,
  input  wire            configDone,
  input  wire            tamperBit,
  input  wire            nvKeyErased,
  input  wire            ioSetChainOut,
  input  wire            bsrChainOut,
  input  wire            bsrUpdData,
  output reg             pinData,
  output reg             pinOe,
  output reg             keepWeakPull,
  output reg             reconfReq,
  output reg             ioSetSel,
  output reg             ioSetShift,
  output reg             bsrSel,
  output reg             secureMode,
  output reg             volKeyErase,
  output reg  [IR_W-1:0] activeInstr
);
  wire [2:0] pinSync;
  reg        tckLast;
  reg  [3:0] tapState;
  reg  [3:0] next_tapState;
  reg  [IR_W-1:0] irShift;
  reg  [31:0] drShift;
  reg        bypassBit;
  reg        pulseInv;
  wire       tckS  = pinSync[0];
  wire       tmsS  = pinSync[1];
  wire       tdiS  = pinSync[2];
  wire       rise  = tckS & ~tckLast;
  wire       fall  = ~tckS & tckLast;

  tapx_pin_sync #(.W(3)) uSync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pinIn    ({tdi, tms, tck}),
    .pinOut   (pinSync)
  );

  // Secure mode allows only a short list; others fall back to bypass.
  function allowed;
    input [IR_W-1:0] code;
    input            secure;
    begin
      allowed = !secure || code == `TAPX_I_BYPASS || code == `TAPX_I_SAMPLE || code == `TAPX_I_EXTEST ||
                code == `TAPX_I_IDCODE || code == `TAPX_I_EDERR || code == `TAPX_I_UNLOCK;
    end
  endfunction

  function isPulse;
    input [IR_W-1:0] code;
    begin
      isPulse = code == `TAPX_I_PULSE || code == `TAPX_I_TRAIN;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    next_tapState = tapState;
    case (tapState)
      `TAPX_S_RESET: next_tapState = tmsS ? `TAPX_S_RESET : `TAPX_S_IDLE;
      `TAPX_S_IDLE:  next_tapState = tmsS ? `TAPX_S_SELDR : `TAPX_S_IDLE;
      `TAPX_S_SELDR: next_tapState = tmsS ? `TAPX_S_SELIR : `TAPX_S_CAPDR;
      `TAPX_S_CAPDR: next_tapState = tmsS ? `TAPX_S_EX1DR : `TAPX_S_SHDR;
      `TAPX_S_SHDR:  next_tapState = tmsS ? `TAPX_S_EX1DR : `TAPX_S_SHDR;
      `TAPX_S_EX1DR: next_tapState = tmsS ? `TAPX_S_UPDR : `TAPX_S_PAUDR;
      `TAPX_S_PAUDR: next_tapState = tmsS ? `TAPX_S_EX2DR : `TAPX_S_PAUDR;
      `TAPX_S_EX2DR: next_tapState = tmsS ? `TAPX_S_UPDR : `TAPX_S_SHDR;
      `TAPX_S_UPDR:  next_tapState = tmsS ? `TAPX_S_SELDR : `TAPX_S_IDLE;
      `TAPX_S_SELIR: next_tapState = tmsS ? `TAPX_S_RESET : `TAPX_S_CAPIR;
      `TAPX_S_CAPIR: next_tapState = tmsS ? `TAPX_S_EX1IR : `TAPX_S_SHIR;
      `TAPX_S_SHIR:  next_tapState = tmsS ? `TAPX_S_EX1IR : `TAPX_S_SHIR;
      `TAPX_S_EX1IR: next_tapState = tmsS ? `TAPX_S_UPIR : `TAPX_S_PAUIR;
      `TAPX_S_PAUIR: next_tapState = tmsS ? `TAPX_S_EX2IR : `TAPX_S_PAUIR;
      `TAPX_S_EX2IR: next_tapState = tmsS ? `TAPX_S_UPIR : `TAPX_S_SHIR;
      default:       next_tapState = tmsS ? `TAPX_S_SELDR : `TAPX_S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // TAP state, instruction register and data registers on rising TCK.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      tckLast     <= 1'b0;
      tapState    <= `TAPX_S_RESET;
      irShift     <= {IR_W{1'b0}};
      drShift     <= 32'h0000_0000;
      bypassBit   <= 1'b0;
      activeInstr <= `TAPX_I_IDCODE;
      secureMode  <= 1'b0;
      reconfReq   <= 1'b0;
      volKeyErase <= 1'b0;
    end else begin
      tckLast     <= tckS;
      reconfReq   <= 1'b0;
      volKeyErase <= 1'b0;
      // Tamper strap is sampled after release while configDone is low, so secure mode is set from the first cycle on.
      if (tamperBit && tapState == `TAPX_S_RESET && !tckLast && !configDone) begin
        secureMode <= 1'b1;
      end
      if (rise) begin
        tapState <= next_tapState;
        case (tapState)
          `TAPX_S_RESET: begin
            activeInstr <= `TAPX_I_IDCODE;
          end
          `TAPX_S_CAPIR: begin
            irShift <= `TAPX_IR_CAPTURE;
          end
          `TAPX_S_SHIR: begin
            irShift <= {tdiS, irShift[IR_W-1:1]};
          end
          `TAPX_S_UPIR: begin
            // Secure enter and exit from the pins are dropped; previous instruction stays.
            if ((irShift == `TAPX_I_LOCK || irShift == `TAPX_I_UNLOCK) && !(coreAccess && userMode)) begin
              activeInstr <= activeInstr;
            end else if (irShift == `TAPX_I_LOCK) begin
              secureMode  <= 1'b1;
              activeInstr <= `TAPX_I_BYPASS;
            end else if (irShift == `TAPX_I_UNLOCK) begin
              secureMode  <= 1'b0;
              activeInstr <= `TAPX_I_BYPASS;
            end else if (!allowed(irShift, secureMode)) begin
              activeInstr <= `TAPX_I_BYPASS;
            end else if (isPulse(irShift) && !(userMode && HAS_PULSE != 0)) begin
              activeInstr <= `TAPX_I_BYPASS;
            end else begin
              activeInstr <= irShift;
              reconfReq   <= irShift == `TAPX_I_RECONF;
              volKeyErase <= irShift == `TAPX_I_KEYCLR;
            end
          end
          `TAPX_S_CAPDR: begin
            bypassBit <= 1'b0;
            if (activeInstr == `TAPX_I_IDCODE) begin
              drShift <= ID_VALUE;
            end else begin
              drShift <= {31'h0000_0000, nvKeyErased};
            end
          end
          `TAPX_S_SHDR: begin
            bypassBit <= tdiS;
            drShift   <= {tdiS, drShift[31:1]};
          end
          default: begin
            irShift <= irShift;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and TDO change on falling TCK, as boundary scan requires.
  always @(posedge core_clk) begin
    if (!rst_b) begin
      tdo          <= 1'b0;
      tdoEn        <= 1'b0;
      pinData      <= 1'b0;
      pinOe        <= 1'b0;
      keepWeakPull <= 1'b0;
      ioSetSel     <= 1'b0;
      ioSetShift   <= 1'b0;
      bsrSel       <= 1'b0;
      pulseInv     <= 1'b0;
    end else begin
      ioSetShift <= 1'b0;
      if (rise) begin
        ioSetShift <= activeInstr == `TAPX_I_IOSET && tapState == `TAPX_S_SHDR;
      end
      if (fall) begin
        ioSetSel     <= activeInstr == `TAPX_I_IOSET;
        bsrSel       <= activeInstr == `TAPX_I_EXTEST || activeInstr == `TAPX_I_SAMPLE || isPulse(activeInstr);
        // Weak pull or bus-hold wins over float and clamp once configured.
        keepWeakPull <= configDone && (activeInstr == `TAPX_I_HIGHZ || activeInstr == `TAPX_I_CLAMP);
        tdoEn        <= tapState == `TAPX_S_SHDR || tapState == `TAPX_S_SHIR;
        if (tapState == `TAPX_S_SHIR) begin
          tdo <= irShift[0];
        end else if (activeInstr == `TAPX_I_IOSET) begin
          tdo <= ioSetChainOut;
        end else if (activeInstr == `TAPX_I_EXTEST || activeInstr == `TAPX_I_SAMPLE || isPulse(activeInstr)) begin
          tdo <= bsrChainOut;
        end else if (activeInstr == `TAPX_I_IDCODE || activeInstr == `TAPX_I_KEYVFY) begin
          tdo <= drShift[0];
        end else begin
          tdo <= bypassBit;
        end
        if (isPulse(activeInstr)) begin
          if (tapState == `TAPX_S_IDLE) begin
            // Train toggles each falling edge in idle; pulse inverts once on entry.
            pulseInv <= (activeInstr == `TAPX_I_TRAIN) ? ~pulseInv : 1'b1;
          end else begin
            pulseInv <= 1'b0;
          end
        end else begin
          pulseInv <= 1'b0;
        end
        if (activeInstr == `TAPX_I_HIGHZ) begin
          pinOe <= 1'b0;
        end else if (activeInstr == `TAPX_I_CLAMP) begin
          pinOe   <= 1'b1;
          pinData <= bsrUpdData;
        end else if (activeInstr == `TAPX_I_EXTEST || isPulse(activeInstr)) begin
          pinOe   <= 1'b1;
          pinData <= bsrUpdData ^ (tapState == `TAPX_S_IDLE ?
                     ((activeInstr == `TAPX_I_TRAIN) ? ~pulseInv : 1'b1) : 1'b0);
        end else begin
          pinOe <= 1'b0;
        end
      end
    end
  end
endmodule

// file: tb/tapx_decode_asserts.sv
// Port assertions for the extended instruction decoder.
`timescale 1ns/1ps
`include "tapx_regs.vh"
module tapx_decode_asserts #(
  parameter IR_W = 10
) (
  input wire            core_clk,
  input wire            rst_b,
  input wire            coreAccess,
  input wire            userMode,
  input wire            configDone,
  input wire            tamperBit,
  input wire            bsrUpdData,
  input wire            pinData,
  input wire            pinOe,
  input wire            keepWeakPull,
  input wire            reconfReq,
  input wire            ioSetSel,
  input wire            ioSetShift,
  input wire            secureMode,
  input wire            volKeyErase,
  input wire [IR_W-1:0] activeInstr
);
  reg [5:0] highzRun;
  reg [5:0] clampRun;
  reg       updLast;
  // Pins follow a new instruction only at the next TCK fall, so the pin checks wait out a long run.
  always @(posedge core_clk) begin
    updLast <= bsrUpdData;
    if (!rst_b || activeInstr != `TAPX_I_HIGHZ) begin
      highzRun <= 6'h00;
    end else if (highzRun != 6'h3f) begin
      highzRun <= highzRun + 6'h01;
    end
    if (!rst_b || activeInstr != `TAPX_I_CLAMP || bsrUpdData != updLast) begin
      clampRun <= 6'h00;
    end else if (clampRun != 6'h3f) begin
      clampRun <= clampRun + 6'h01;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_reset_ident: assert property ($rose(rst_b) |-> activeInstr == `TAPX_I_IDCODE)
    else $error("instruction after reset is not identification");
  a_reconf_cause: assert property (reconfReq |-> ##[0:2] activeInstr == `TAPX_I_RECONF)
    else $error("reconfigure request without its instruction");
  a_key_cause: assert property (volKeyErase |-> ##[0:2] activeInstr == `TAPX_I_KEYCLR)
    else $error("key erase without its instruction");
  a_highz_float: assert property (highzRun >= 6'h28 |-> !pinOe && keepWeakPull == configDone)
    else $error("pin not floated or pull not kept");
  a_clamp_hold: assert property (clampRun >= 6'h28 |-> pinOe && pinData == bsrUpdData &&
    keepWeakPull == configDone)
    else $error("clamped pin differs from update stage");
  a_ioset_shift: assert property (ioSetShift |-> ioSetSel)
    else $error("setting chain shifted while not selected");
  a_lock_core: assert property ($changed(secureMode) |-> ($past(coreAccess) && $past(userMode)) || tamperBit)
    else $error("secure instruction taken from the pins");
  a_secure_filter: assert property (secureMode && $changed(activeInstr) |-> activeInstr inside {
    `TAPX_I_BYPASS, `TAPX_I_SAMPLE, `TAPX_I_EXTEST, `TAPX_I_IDCODE, `TAPX_I_EDERR, `TAPX_I_UNLOCK, `TAPX_I_LOCK})
    else $error("instruction outside the secure set");
  a_secure_cause: assert property ($rose(secureMode) |-> activeInstr == `TAPX_I_BYPASS || tamperBit)
    else $error("secure mode entered without cause");
  a_pulse_gate: assert property (activeInstr inside {`TAPX_I_PULSE, `TAPX_I_TRAIN} |-> userMode)
    else $error("pulse test active outside user mode");
endmodule
bind tapx_decode tapx_decode_asserts #(.IR_W(IR_W)) chk_u (.core_clk(core_clk), .rst_b(rst_b),
  .coreAccess(coreAccess), .userMode(userMode), .configDone(configDone), .tamperBit(tamperBit),
  .bsrUpdData(bsrUpdData), .pinData(pinData), .pinOe(pinOe), .keepWeakPull(keepWeakPull), .reconfReq(reconfReq),
  .ioSetSel(ioSetSel), .ioSetShift(ioSetShift), .secureMode(secureMode), .volKeyErase(volKeyErase),
  .activeInstr(activeInstr));

// file: tb/tapx_jtag_host.sv
// Behavioural boundary-scan controller driving the test port pins.
`timescale 1ns/1ps
module tapx_jtag_host (
  input  wire core_clk,
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo
);
  // Between frames the clock stands low and released data lines sit at their pull-up.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One TCK period of 25 core clocks; every pin moves just after a core clock edge.
  task step(input reg m, input reg d, output reg q);
    begin
      tms <= m;
      tdi <= d;
      repeat (12) @(posedge core_clk);
      tck <= 1'b1;
      q = tdo;
      repeat (13) @(posedge core_clk);
      tck <= 1'b0;
    end
  endtask
  // Leaves and re-enters Run-Test/Idle; LSB goes first, as the scan registers shift.
  task scan(input reg ir, input reg [31:0] v, input integer n, output reg [31:0] o);
    integer i;
    reg     q;
    begin
      o = 32'h0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1, v[i], q);
        o[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      tms <= 1'b1;
      tdi <= 1'b1;
      // The last fall reaches the outputs only after the synchroniser, so let it settle.
      repeat (8) @(posedge core_clk);
    end
  endtask
endmodule

// file: tb/tapx_decode_test.sv
// Self-checking bench for the extended instruction decoder.
`timescale 1ns/1ps
`include "tapx_regs.vh"
module tapx_decode_test;
  reg        core_clk, rst_b, coreAccess, userMode, configDone, tamperBit;
  reg        nvKeyErased, ioSetChainOut, bsrChainOut, bsrUpdData, p, q;
  wire       tck, tms, tdi, tdo, tdoEn, pinData, pinOe, keepWeakPull, reconfReq;
  wire       ioSetSel, ioSetShift, bsrSel, secureMode, volKeyErase;
  wire [9:0] activeInstr;
  integer    errors, n_tests, seed, nRec, nKey, nShift;
  reg [31:0] o;
  reg [9:0]  expq[$];
  event      irDone;
  tapx_jtag_host host_u (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  tapx_decode dut_u (.core_clk(core_clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEn(tdoEn), .coreAccess(coreAccess), .userMode(userMode), .configDone(configDone), .tamperBit(tamperBit),
    .nvKeyErased(nvKeyErased), .ioSetChainOut(ioSetChainOut), .bsrChainOut(bsrChainOut), .bsrUpdData(bsrUpdData),
    .pinData(pinData), .pinOe(pinOe), .keepWeakPull(keepWeakPull), .reconfReq(reconfReq), .ioSetSel(ioSetSel),
    .ioSetShift(ioSetShift), .bsrSel(bsrSel), .secureMode(secureMode), .volKeyErase(volKeyErase),
    .activeInstr(activeInstr));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ioSetChainOut <= 1'($random(seed));
    bsrChainOut <= 1'($random(seed));
    nRec <= nRec + reconfReq;
    nKey <= nKey + volKeyErase;
    nShift <= nShift + ioSetShift;
  end
  task check(input reg [31:0] got, input reg [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task load(input reg [9:0] c, input reg [9:0] e);
    begin
      host_u.scan(1'b1, {22'h0, c}, 10, o);
      check(o, 32'h1);
      expq.push_back(e);
      -> irDone;
    end
  endtask
  task reset_dut;
    begin
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (12) @(posedge core_clk);
    end
  endtask
  // The watcher takes the oldest expectation once an instruction load frame has ended in Run-Test/Idle.
  initial forever begin
    @(irDone);
    check(activeInstr, expq.pop_front());
  end
  // A hung frame would stall the main sequence, so a bounded watchdog closes the run.
  initial begin
    repeat (90000) @(posedge core_clk);
    errors = errors + 1;
    complete_run;
  end
  initial begin
    {rst_b, coreAccess, tamperBit, bsrUpdData} = 4'h0;
    {userMode, configDone} = 2'h3;
    {errors, n_tests, nRec, nKey, nShift} = 0;
    seed = 35;
    nvKeyErased = 1'b1;
    reset_dut;
    host_u.step(1'b0, 1'b1, q);
    host_u.scan(1'b0, 32'h0, 32, o);
    check(o, `TAPX_ID_VALUE);
    load(`TAPX_I_HIGHZ, `TAPX_I_HIGHZ);
    check({pinOe, keepWeakPull}, 2'h1);
    bsrUpdData <= 1'($random(seed));
    load(`TAPX_I_CLAMP, `TAPX_I_CLAMP);
    check({pinOe, pinData}, {1'b1, bsrUpdData});
    load(`TAPX_I_RECONF, `TAPX_I_RECONF);
    load(`TAPX_I_IOSET, `TAPX_I_IOSET);
    host_u.scan(1'b0, 32'h5, 4, o);
    check({ioSetSel, nShift[3:0]}, 5'h14);
    load(`TAPX_I_KEYCLR, `TAPX_I_KEYCLR);
    nvKeyErased <= 1'($random(seed));
    load(`TAPX_I_KEYVFY, `TAPX_I_KEYVFY);
    host_u.scan(1'b0, 32'h0, 1, o);
    check(o[0], nvKeyErased);
    load(`TAPX_I_PULSE, `TAPX_I_PULSE);
    check(pinData, !bsrUpdData);
    load(`TAPX_I_TRAIN, `TAPX_I_TRAIN);
    p = pinData;
    host_u.step(1'b0, 1'b1, q);
    repeat (8) @(posedge core_clk);
    check(pinData, !p);
    load(`TAPX_I_LOCK, `TAPX_I_TRAIN);
    @(posedge core_clk);
    coreAccess <= 1'b1;
    load(`TAPX_I_LOCK, `TAPX_I_BYPASS);
    check(secureMode, 1'b1);
    load(`TAPX_I_CLAMP, `TAPX_I_BYPASS);
    load(`TAPX_I_EXTEST, `TAPX_I_EXTEST);
    check({bsrSel, tdoEn}, 2'h2);
    load(`TAPX_I_UNLOCK, `TAPX_I_BYPASS);
    check(secureMode, 1'b0);
    @(posedge core_clk);
    {coreAccess, userMode} <= 2'h0;
    load(`TAPX_I_PULSE, `TAPX_I_BYPASS);
    check({nRec[1:0], nKey[1:0]}, 4'h5);
    {tamperBit, configDone} <= 2'h2;
    reset_dut;
    check(secureMode, 1'b1);
    complete_run;
  end
endmodule
